// ### rtl/link_ctrl_pkg.sv
/*
 * Shared constants and types for the per-port link capability and link
 * control register block: offsets, field positions, reset values, timing.
 * Assumes a 100 MHz core clock and 32-bit AXI4-Lite configuration access.
 */
package link_ctrl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_LINK_CAP = 12'h04c;
  localparam logic [11:0] OFF_LINK_CTL = 12'h050;
  localparam logic [11:0] OFF_SW_CTL = 12'h060;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CAP_BWN_POS = 21;
  localparam int CAP_PORT_LSB = 24;
  localparam int CTL_ASPM_LSB = 0;
  localparam int CTL_RCB_POS = 3;
  localparam int CTL_LINK_DISABLE_BIT_POS = 4;
  localparam int CTL_RETRAIN_POS = 5;
  localparam int CTL_COMMON_REFCLK_CONFIG_POS = 6;
  localparam int CTL_LBWIE_POS = 10;
  localparam int CTL_LABWIE_POS = 11;
  localparam int SW_UNLOCK_POS = 0;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ASPM_OFF = 2'h0;
  localparam logic [1:0] ASPM_L0S = 2'h1;
  localparam logic [1:0] ASPM_L1 = 2'h2;
  localparam logic [1:0] ASPM_L0S_L1 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RETRAIN_DELAY_NS = 1000000;
  localparam int RETRAIN_DELAY_CYC = RETRAIN_DELAY_NS / CLK_PERIOD_NS;

  // link control settings as seen by the training logic
  typedef struct packed {
    logic lab_int_en;
    logic lbw_int_en;
    logic common_clk;
    logic link_dis;
    logic [1:0] aspm;
  } link_ctl_t;

  localparam link_ctl_t CTL_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, ASPM_OFF};

  // retrain sequencer, gray coded along idle-wait-delay-fire
  typedef enum logic [1:0] {
    RT_IDLE = 2'h0,
    RT_WAIT_RESP = 2'h1,
    RT_DELAY = 2'h3,
    RT_FIRE = 2'h2
  } rt_state_t;

endpackage

// ### rtl/link_ctrl_regs.sv
/*
 * Link capability and link control registers of one switch port, reached
 * over AXI4-Lite, plus the retrain request towards link training.
 * Assumes the training logic runs on aclk and reports Recovery or
 * Configuration as a level; eeprom load strobe comes from same clock.
 */
`timescale 1ns/1ps

// Functional notes
// - bandwidth notify capable: downstream one, upstream zero
// - capability top byte reports port number
// - aspm field: off, L0s, L1, both
// - aspm resets off, eeprom load may override
// - L0s enable governs transmitter only
// - read completion boundary hardwired zero
// - link disable acts downstream; upstream keeps zero
// - writing retrain one starts recovery
// - retrain bit always reads zero
// - retrain write may update other fields
// - changes deferred if retrain written while training busy
// - upstream retrain ignored while unlock clear
// - unlocked upstream retrain fires after 1 ms
// - write response precedes retrain effect
// - common clock bit read-write, reset zero
// - bandwidth interrupt enables zero without capability
module link_ctrl_regs
  import link_ctrl_pkg::*;
#(
  parameter int unsigned PORT_NUM = 0,
  parameter int unsigned RETRAIN_DELAY = RETRAIN_DELAY_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic eeprom_aspm_load,
  input wire logic [1:0] eeprom_aspm,
  input wire logic ltssm_recov_or_cfg,
  output link_ctl_t ctl_applied,
  output logic tx_l0s_entry_en,
  output logic l1_entry_en,
  output logic retrain_req
);

  // ----------------------------------------------------------------
  // port identity
  // ----------------------------------------------------------------
  // port 0 is the upstream port of the switch
  localparam logic UPSTREAM = (PORT_NUM == 0);
  localparam logic BWN_CAP = !UPSTREAM;
  localparam int DLY_W = $clog2(RETRAIN_DELAY + 1);
  localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(RETRAIN_DELAY - 1);

  // port number in top byte, capability bit
  localparam logic [31:0] CAP_WORD =
    (32'(PORT_NUM & 8'hff) << CAP_PORT_LSB) |
    (32'(BWN_CAP) << CAP_BWN_POS);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  link_ctl_t ctl_q, ctl_d, appl_q, appl_d;
  logic unlock_q, unlock_d, defer_q, defer_d;
  rt_state_t rt_q, rt_d;
  logic [DLY_W-1:0] dly_q, dly_d;

  logic aw_hs, w_hs, ar_hs, do_wr, retrain_wr;
  logic [ADDR_W-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [15:0] ctl_word;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // one write in flight: both channels stall until the response drains
  assign awready = !aw_have_q && !bvalid_q;
  assign wready = !w_have_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign ar_hs = arvalid && arready;
  assign wa = aw_hs ? awaddr : waddr_q;
  assign wd = w_hs ? wdata : wdata_q;
  assign ws = w_hs ? wstrb : wstrb_q;
  assign do_wr = (aw_have_q || aw_hs) && (w_have_q || w_hs);

  // ----------------------------------------------------------------
  // readback image of link control
  // ----------------------------------------------------------------
  always_comb begin
    ctl_word = 16'h0000;
    ctl_word[CTL_ASPM_LSB +: 2] = ctl_q.aspm;
    ctl_word[CTL_RCB_POS] = 1'b0;
    ctl_word[CTL_LINK_DISABLE_BIT_POS] = ctl_q.link_dis;
    ctl_word[CTL_RETRAIN_POS] = 1'b0;
    ctl_word[CTL_COMMON_REFCLK_CONFIG_POS] = ctl_q.common_clk;
    ctl_word[CTL_LBWIE_POS] = ctl_q.lbw_int_en;
    ctl_word[CTL_LABWIE_POS] = ctl_q.lab_int_en;
  end

  // ----------------------------------------------------------------
  // write channel and register updates
  // ----------------------------------------------------------------
  always_comb begin
    aw_have_d = (aw_have_q || aw_hs) && !do_wr;
    w_have_d = (w_have_q || w_hs) && !do_wr;
    waddr_d = wa;
    wdata_d = wd;
    wstrb_d = ws;
    bvalid_d = do_wr || (bvalid_q && !bready);
    bresp_d = bresp_q;
    ctl_d = ctl_q;
    unlock_d = unlock_q;
    retrain_wr = 1'b0;
    // eeprom value replaces reset default; software write wins
    if (eeprom_aspm_load) begin
      ctl_d.aspm = eeprom_aspm;
    end
    if (do_wr) begin
      bresp_d = RESP_OKAY;
      if (wa[ADDR_W-1:2] == OFF_LINK_CTL[ADDR_W-1:2]) begin
        if (ws[0]) begin
          ctl_d.aspm = wd[CTL_ASPM_LSB +: 2];
          // link disable only on downstream ports
          ctl_d.link_dis = !UPSTREAM && wd[CTL_LINK_DISABLE_BIT_POS];
          ctl_d.common_clk = wd[CTL_COMMON_REFCLK_CONFIG_POS];
          retrain_wr = wd[CTL_RETRAIN_POS] && (!UPSTREAM || unlock_q);
        end
        if (ws[1]) begin
          ctl_d.lbw_int_en = BWN_CAP && wd[CTL_LBWIE_POS];
          ctl_d.lab_int_en = BWN_CAP && wd[CTL_LABWIE_POS];
        end
      end else if (wa[ADDR_W-1:2] == OFF_SW_CTL[ADDR_W-1:2]) begin
        if (ws[0]) begin
          unlock_d = wd[SW_UNLOCK_POS];
        end
      end else if (wa[ADDR_W-1:2] != OFF_LINK_CAP[ADDR_W-1:2]) begin
        bresp_d = RESP_SLVERR; // unmapped
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    rvalid_d = ar_hs || (rvalid_q && !rready);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_hs) begin
      rresp_d = RESP_OKAY;
      if (araddr[ADDR_W-1:2] == OFF_LINK_CAP[ADDR_W-1:2]) begin
        rdata_d = CAP_WORD;
      end else if (araddr[ADDR_W-1:2] == OFF_LINK_CTL[ADDR_W-1:2]) begin
        rdata_d = {16'h0000, ctl_word};
      end else if (araddr[ADDR_W-1:2] == OFF_SW_CTL[ADDR_W-1:2]) begin
        rdata_d = {31'h00000000, unlock_q};
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // retrain sequencer
  // ----------------------------------------------------------------
  // the request waits for the write response to be taken, so the
  // requester always sees its completion before the link drops.
  // a second retrain while one is pending merges into it.
  always_comb begin
    rt_d = rt_q;
    dly_d = dly_q;
    case (rt_q)
      RT_IDLE: begin
        if (retrain_wr) begin
          rt_d = RT_WAIT_RESP;
        end
      end
      RT_WAIT_RESP: begin
        if (bvalid_q && bready) begin
          if (UPSTREAM) begin
            rt_d = RT_DELAY;
            dly_d = DLY_LOAD;
          end else begin
            rt_d = RT_FIRE;
          end
        end
      end
      RT_DELAY: begin
        if (dly_q == '0) begin
          rt_d = RT_FIRE;
        end else begin
          dly_d = dly_q - 1'b1;
        end
      end
      RT_FIRE: begin
        // a retrain taken during the pulse must not be lost
        if (retrain_wr) begin
          rt_d = RT_WAIT_RESP;
        end else begin
          rt_d = RT_IDLE;
        end
      end
      default: begin
        rt_d = RT_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // settings handed to the training logic
  // ----------------------------------------------------------------
  // freeze applied settings from a retrain write taken while training busy until its pulse
  always_comb begin
    defer_d = defer_q;
    appl_d = defer_q ? appl_q : ctl_q;
    if (rt_q == RT_FIRE) begin
      defer_d = 1'b0;
      appl_d = ctl_q;
    end
    // a new deferral in the pulse cycle wins over the clear
    if (retrain_wr && ltssm_recov_or_cfg) begin
      defer_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      waddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      // aspm off at reset, common clock zero
      ctl_q <= CTL_RESET;
      appl_q <= CTL_RESET;
      unlock_q <= 1'b0;
      defer_q <= 1'b0;
      rt_q <= RT_IDLE;
      dly_q <= '0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctl_q <= ctl_d;
      appl_q <= appl_d;
      unlock_q <= unlock_d;
      defer_q <= defer_d;
      rt_q <= rt_d;
      dly_q <= dly_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign ctl_applied = appl_q;
  assign tx_l0s_entry_en = appl_q.aspm[0];
  assign l1_entry_en = appl_q.aspm[1];
  assign retrain_req = (rt_q == RT_FIRE);

endmodule

// ### verification/link_ctrl_regs_assertions.sv
/* checker for the link control register block, bound to each instance
   assumes aligned AXI4-Lite accesses, address and data offered together */
`timescale 1ns/1ps
module link_ctrl_checker
  import link_ctrl_pkg::*;
#(
  parameter int unsigned PORT_NUM = 0,
  parameter int unsigned RETRAIN_DELAY = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire link_ctl_t ctl_applied,
  input wire logic tx_l0s_entry_en,
  input wire logic l1_entry_en,
  input wire logic retrain_req
);
  // upstream waits out the long delay, downstream fires next cycle
  localparam int LAG = (PORT_NUM == 0) ? RETRAIN_DELAY + 1 : 1;
  logic ret_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // remembers a taken retrain write until its response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ret_q <= 1'b0;
    end else if (awvalid && awready && wvalid && wready) begin
      ret_q <= awaddr == OFF_LINK_CTL && wstrb[0] && wdata[CTL_RETRAIN_POS];
    end else if (bvalid && bready) begin
      ret_q <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_wr_resp;
    awvalid && awready && wvalid && wready |=> bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_rd_resp;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read data");
  property p_pulse;
    retrain_req |=> !retrain_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long retrain");
  property p_down_fire;
    PORT_NUM != 0 && ret_q && bvalid && bready |=> retrain_req;
  endproperty
  a_down_fire: assert property (p_down_fire) else $error("no retrain");
  property p_lag;
    retrain_req |-> $past(bvalid && bready, LAG);
  endproperty
  a_lag: assert property (p_lag) else $error("retrain mistimed");
  property p_ro_bits;
    rvalid |-> !rdata[CTL_RETRAIN_POS] && !rdata[CTL_RCB_POS];
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("bit not zero");
  property p_lanes;
    tx_l0s_entry_en == ctl_applied.aspm[0] && l1_entry_en == ctl_applied.aspm[1];
  endproperty
  a_lanes: assert property (p_lanes) else $error("aspm enables wrong");
  property p_up;
    PORT_NUM == 0 |-> !ctl_applied.link_dis && !ctl_applied.lbw_int_en
      && !ctl_applied.lab_int_en;
  endproperty
  a_up: assert property (p_up) else $error("upstream field set");
  property p_rst;
    $rose(aresetn) |-> ctl_applied == CTL_RESET && !bvalid && !retrain_req;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  c_retrain: cover property (retrain_req);
  c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
  c_common_refclk_config: cover property (rvalid && rdata[CTL_COMMON_REFCLK_CONFIG_POS]);
endmodule

bind link_ctrl_regs link_ctrl_checker #(
  .PORT_NUM(PORT_NUM), .RETRAIN_DELAY(RETRAIN_DELAY)
) chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
  .ctl_applied(ctl_applied), .tx_l0s_entry_en(tx_l0s_entry_en),
  .l1_entry_en(l1_entry_en), .retrain_req(retrain_req));

// ### verification/ltssm_model.sv
/* link training partner: enters recovery briefly on each retrain pulse
   assumes it shares aclk and aresetn with the register block */
`timescale 1ns/1ps
module ltssm_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic retrain_req,
  input wire logic hold_busy,
  output logic ltssm_recov_or_cfg
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  // a request steers training into recovery
  always_comb begin
    cnt_d = cnt_q;
    if (retrain_req) begin
      cnt_d = 2'h2;
    end else if (cnt_q != 2'h0) begin
      cnt_d = cnt_q - 2'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // hold_busy parks training in configuration for deferral tests
  assign ltssm_recov_or_cfg = hold_busy || cnt_q != 2'h0;
endmodule

// ### verification/testbench.sv
/* testbench: one upstream and one downstream register block on one bus
   assumes both answer alike in time; port 0 handshakes are followed */
`timescale 1ns/1ps
module testbench
  import link_ctrl_pkg::*;
();
  localparam int DLY = 20;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, aload, hold;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, seed, v, r0, r1;
  logic [3:0] wstrb;
  logic [1:0] easpm, rs;
  logic awready[2], wready[2], bvalid[2], arready[2], rvalid[2], busy[2];
  logic retrain_req[2], tx_l0s[2], l1_en[2];
  logic [1:0] bresp[2], rresp[2];
  logic [31:0] rdata[2];
  link_ctl_t ctl_applied[2], pre[2], post[2];
  int errors, num_checks, hit[2];
  for (genvar g = 0; g < 2; g++) begin : g_port
    link_ctrl_regs #(.PORT_NUM(2 * g), .RETRAIN_DELAY(DLY)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready[g]), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready[g]),
      .bresp(bresp[g]), .bvalid(bvalid[g]), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready[g]), .rdata(rdata[g]), .rresp(rresp[g]),
      .rvalid(rvalid[g]), .rready(rready), .eeprom_aspm_load(aload),
      .eeprom_aspm(easpm), .ltssm_recov_or_cfg(busy[g]),
      .ctl_applied(ctl_applied[g]), .tx_l0s_entry_en(tx_l0s[g]),
      .l1_entry_en(l1_en[g]), .retrain_req(retrain_req[g]));
    ltssm_model partner (.aclk(aclk), .aresetn(aresetn),
      .retrain_req(retrain_req[g]), .hold_busy(hold),
      .ltssm_recov_or_cfg(busy[g]));
  end
  // ------------------------------------------------------------
  // expectations and helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] cap_exp(input int p);
    return {p[7:0], 2'h0, p != 0, 21'h0};
  endfunction
  // upstream keeps only aspm and common clock writable
  function automatic logic [31:0] ctl_exp(input int p, input logic [31:0] d);
    return d & (p != 0 ? 32'h0c53 : 32'h0043);
  endfunction
  function automatic link_ctl_t app_exp(input logic [31:0] m);
    return '{m[11], m[10], m[6], m[4], m[1:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    errors++;
    $display("Error %0t: timeout", $time);
    give_verdict();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready[0]) awvalid <= 1'b0;
      if (wready[0]) wvalid <= 1'b0;
    end while (bvalid[0] !== 1'b1 && n < 50);
    bready <= 1'b0;
    rs = bresp[0];
    if (n >= 50) tmo();
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready[0]) arvalid <= 1'b0;
    end while (rvalid[0] !== 1'b1 && n < 50);
    rready <= 1'b0;
    r0 = rdata[0];
    r1 = rdata[1];
    rs = rresp[0];
    if (n >= 50) tmo();
  endtask
  // records first retrain pulse and the applied settings around it
  task automatic watch();
    hit = '{-1, -1};
    for (int n = 1; n <= 40; n++) begin
      @(posedge aclk);
      for (int k = 0; k < 2; k++) begin
        if (hit[k] == n - 1) post[k] = ctl_applied[k];
        if (retrain_req[k] === 1'b1 && hit[k] < 0) begin
          hit[k] = n;
          pre[k] = ctl_applied[k];
        end
      end
    end
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    tmo();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, aload, hold} = '0;
    {awaddr, araddr, wdata, easpm} = '0;
    wstrb = 4'hf;
    errors = 0;
    num_checks = 0;
    seed = 32'h82dae180;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_LINK_CAP);
    chk(r0, cap_exp(0));
    chk(r1, cap_exp(2));
    rd(OFF_LINK_CTL);
    chk(r0 | r1, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      v = (i < 4) ? i : seed;
      wr(OFF_LINK_CTL, v);
      rd(OFF_LINK_CTL);
      chk(r0, ctl_exp(0, v));
      chk(r1, ctl_exp(2, v));
      for (int k = 0; k < 2; k++) begin
        chk(ctl_applied[k], app_exp(ctl_exp(2 * k, v)));
        chk(tx_l0s[k], v[0]);
        chk(l1_en[k], v[1]);
      end
    end
    $display("field test done");
    wr(OFF_LINK_CAP, 32'hffffffff);
    rd(OFF_LINK_CAP);
    chk(r1, cap_exp(2));
    wr(12'h100, 32'hffffffff);
    chk(rs, RESP_SLVERR);
    rd(12'h100);
    chk(r0, 32'h0);
    chk(rs, RESP_SLVERR);
    wr(OFF_LINK_CTL, 32'h0);
    @(posedge aclk);
    aload <= 1'b1;
    easpm <= ASPM_L1;
    @(posedge aclk);
    aload <= 1'b0;
    rd(OFF_LINK_CTL);
    chk(r0[1:0], ASPM_L1);
    chk(r1[1:0], ASPM_L1);
    $display("map test done");
    wr(OFF_LINK_CTL, 32'h22);
    watch();
    chk(hit[1], 1);
    chk(hit[0], -1);
    wr(OFF_SW_CTL, 32'h1);
    rd(OFF_SW_CTL);
    chk(r0, 32'h1);
    hold <= 1'b1;
    wr(OFF_LINK_CTL, 32'h63);
    watch();
    hold <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      chk(hit[k], k ? 1 : DLY + 1);
      chk(pre[k], app_exp(32'h2));
      chk(post[k], app_exp(ctl_exp(2 * k, 32'h63)));
    end
    $display("retrain test done");
    give_verdict();
  end
endmodule
